/* src/pla_cfg.svh */
// register offsets, field positions, reset values for the palette access block
`ifndef PLA_CFG_SVH
`define PLA_CFG_SVH

// register indices; the byte address is four times the index
`define PLA_IDX_POINTER     8'h15
`define PLA_IDX_BANK        8'h16
`define PLA_IDX_DATA        8'h17
`define PLA_ADDR_POINTER    ({2'b00, `PLA_IDX_POINTER} << 2)
`define PLA_ADDR_BANK       ({2'b00, `PLA_IDX_BANK} << 2)
`define PLA_ADDR_DATA       ({2'b00, `PLA_IDX_DATA} << 2)
`define PLA_ADDR_W          10

// pointer register fields
`define PLA_PTR_POS_LSB     0
`define PLA_PTR_SEL_LSB     4

// bank register field positions (msb of the red two-bit field) and register width
`define PLA_BANK_RED_MSB    5
`define PLA_BANK_WIDTH      6

// reset values
`define PLA_RST_POS         4'h0
`define PLA_RST_SEL         2'h0
`define PLA_RST_BANK        6'h00

`endif

/* src/pla_pkg.sv */
// types shared by the palette access block
package pla_pkg;

    // table select field of the pointer register
    typedef enum logic [1:0] {
        PLA_SEL_AUTO,
        PLA_SEL_RED,
        PLA_SEL_GREEN,
        PLA_SEL_BLUE
    } pla_sel_t;

    // which table the pointer currently rests on
    typedef enum logic [1:0] {
        PLA_CH_RED,
        PLA_CH_GREEN,
        PLA_CH_BLUE
    } pla_ch_t;

    // display depth
    typedef enum logic [1:0] {
        PLA_BPP1,
        PLA_BPP2,
        PLA_BPP4,
        PLA_BPP8
    } pla_bpp_t;

    // bus state
    typedef enum logic {
        PLA_BUS_IDLE,
        PLA_BUS_DATA
    } pla_bus_t;

    // captured address phase
    typedef struct packed {
        logic [9:0] addr;
        logic       write;
    } pla_req_t;

    // one displayed colour
    typedef struct packed {
        logic [3:0] red;
        logic [3:0] green;
        logic [3:0] blue;
    } pla_rgb_t;

endpackage

/* src/pla_palette.sv */
// palette tables, pointer and bank select behind an AHB-Lite slave
`timescale 1ns/1ns
`include "pla_cfg.svh"

// Behaviour
// - Pointer bits 5-4 choose red, green, blue or automatic red-green-blue stepping.
// - In monochrome operation software uses select 10b and data accesses go to the green table.
// - Pointer bits 3-0 pick one of sixteen entries of the chosen table.
// - Each data window read or write advances the pointer; the readable position moves on each access, but under automatic stepping only after blue.
// - With a single table selected each data access steps the position by one in that table.
// - Writing the pointer with select 00 in colour mode places it on red at the written position.
// - Automatic stepping visits red, green, blue at one position, then red at the next.
// - The data window's low four bits read or write the addressed entry; upper bits are unused.
// - At 1 bpp red and blue use their lower eight entries as four two-entry banks.
// - At 1 bpp the green bank field picks one of four two-entry banks in the lower eight entries.
// - At 2 bpp each table splits into four four-entry banks chosen by its bank field.
// - At 4 bpp all bank fields are ignored and full tables are used.
// - At 8 bpp red and green split into two eight-entry banks chosen by bank bit 4 for red and bank bit 2 for green.
// - At 8 bpp blue splits into four four-entry banks chosen by both blue bank bits.
// - Bank register holds red in bits 5-4, green in 3-2, blue in 1-0, bits 7-6 unused.
// - Three palettes, red, green and blue, each of sixteen four-bit entries.
module pla_palette (
    input  wire logic                core_clk,
    input  wire logic                rst,
    input  wire logic                ce,
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic                     hreadyout,
    output logic                     hresp,
    output logic [31:0]              hrdata,
    input  wire logic                colour_mode,
    input  wire pla_pkg::pla_bpp_t   bpp,
    input  wire logic [7:0]          pixel,
    output pla_pkg::pla_rgb_t        rgb_out
);

    ////////////////////////////////////////////////////////////////////////////
    // state

    logic [3:0]           lut [0:2][0:15];
    logic [3:0]           pos;
    pla_pkg::pla_sel_t    sel;
    pla_pkg::pla_ch_t     phase;
    logic [5:0]           bank;
    pla_pkg::pla_bus_t    bus;
    pla_pkg::pla_req_t    req;

    ////////////////////////////////////////////////////////////////////////////
    // bus decode

    // address phase taken only when the bus is ready; hsize is not checked
    wire take     = ce && hsel && htrans[1] && hready && bus == pla_pkg::PLA_BUS_IDLE;
    wire in_data  = ce && bus == pla_pkg::PLA_BUS_DATA;
    wire hit_ptr  = req.addr == `PLA_ADDR_W'(`PLA_ADDR_POINTER);
    wire hit_bank = req.addr == `PLA_ADDR_W'(`PLA_ADDR_BANK);
    wire hit_data = req.addr == `PLA_ADDR_W'(`PLA_ADDR_DATA);
    wire wr_ptr   = in_data && req.write && hit_ptr;
    wire wr_bank  = in_data && req.write && hit_bank;
    wire acc_data = in_data && hit_data;
    wire wr_data  = acc_data && req.write;
    wire auto_sel = sel == pla_pkg::PLA_SEL_AUTO && colour_mode;

    ////////////////////////////////////////////////////////////////////////////
    // table that the window reaches now

    // monochrome always lands on the gray table, whatever the select says
    wire pla_pkg::pla_ch_t tgt =
        !colour_mode ? pla_pkg::PLA_CH_GREEN :
        sel == pla_pkg::PLA_SEL_AUTO ? phase :
        pla_pkg::pla_ch_t'(2'(sel - 2'h1));
    wire [3:0] entry = lut[tgt][pos];

    ////////////////////////////////////////////////////////////////////////////
    // pointer stepping

    wire last_phase = phase == pla_pkg::PLA_CH_BLUE;
    wire [3:0] pos_inc = 4'(pos + 4'h1);
    wire [3:0] next_pos = auto_sel && !last_phase ? pos : pos_inc;
    wire pla_pkg::pla_ch_t next_phase =
        !auto_sel || last_phase ? pla_pkg::PLA_CH_RED :
        pla_pkg::pla_ch_t'(2'(phase + 2'h1));

    ////////////////////////////////////////////////////////////////////////////
    // read mux

    // unmapped words read zero; reserved bits above each field read zero
    wire [31:0] rd_val =
        hit_ptr  ? {26'h000_0000, sel, pos} :
        hit_bank ? {26'h000_0000, bank} :
        hit_data ? {28'h000_0000, entry} :
        32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////////
    // bus handshake: one wait state, then the answer

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            bus       <= pla_pkg::PLA_BUS_IDLE;
            req       <= '0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= 32'h0000_0000;
        end
        else if (take)
        begin
            bus       <= pla_pkg::PLA_BUS_DATA;
            req       <= '{addr: haddr[9:0], write: hwrite};
            hreadyout <= 1'b0;
        end
        else if (in_data)
        begin
            bus       <= pla_pkg::PLA_BUS_IDLE;
            hreadyout <= 1'b1;
            hrdata    <= req.write ? 32'h0000_0000 : rd_val;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pointer and bank registers

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            pos   <= `PLA_RST_POS;
            sel   <= pla_pkg::pla_sel_t'(`PLA_RST_SEL);
            phase <= pla_pkg::PLA_CH_RED;
            bank  <= `PLA_RST_BANK;
        end
        else if (wr_ptr)
        begin
            pos   <= hwdata[`PLA_PTR_POS_LSB +: 4];
            sel   <= pla_pkg::pla_sel_t'(hwdata[`PLA_PTR_SEL_LSB +: 2]);
            phase <= pla_pkg::PLA_CH_RED;
        end
        else if (wr_bank)
        begin
            bank <= hwdata[`PLA_BANK_WIDTH-1:0];
        end
        else if (acc_data)
        begin
            pos   <= next_pos;
            phase <= next_phase;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // palette store; no reset, software loads it before display starts

    always_ff @(posedge core_clk)
    begin
        if (wr_data)
        begin
            lut[tgt][pos] <= hwdata[3:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // display lookup, one lane per colour

    logic [3:0] lidx [0:2];
    logic [3:0] lval [0:2];

    genvar ch;
    generate
        for (ch = 0; ch < 3; ch++)
        begin : g_lane
            // red bits 5-4, green 3-2, blue 1-0
            wire [1:0] bsel = bank[`PLA_BANK_RED_MSB - 2*ch -: 2];
            // at 8 bpp red and green take three pixel bits, blue two
            wire [2:0] p8 = ch == 0 ? pixel[7:5] : ch == 1 ? pixel[4:2] : {1'b0, pixel[1:0]};
            wire [3:0] idx8 = ch == 2 ? {bsel, pixel[1:0]} :
                              {bsel[0], p8};
            assign lidx[ch] =
                bpp == pla_pkg::PLA_BPP1 ? {1'b0, bsel, pixel[0]} :
                bpp == pla_pkg::PLA_BPP2 ? {bsel, pixel[1:0]} :
                bpp == pla_pkg::PLA_BPP4 ? pixel[3:0] :
                idx8;
            assign lval[ch] = lut[ch][lidx[ch]];
        end
    endgenerate

    // registered so the display sees a clean colour one cycle after the pixel
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            rgb_out <= '0;
        end
        else if (ce)
        begin
            rgb_out <= '{red: lval[0], green: lval[1], blue: lval[2]};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks: pointer and data window

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst || !ce);

    // a pointer write lands on red at the written position
    a_ptr_write_place: assert property (
        wr_ptr |=> pos == $past(hwdata[3:0]) && phase == pla_pkg::PLA_CH_RED)
        else $error("pointer write did not place pointer on red");

    // the select field takes bits 5-4 of the written word
    a_ptr_write_sel: assert property (
        wr_ptr |=> sel == $past(hwdata[5:4]))
        else $error("pointer write did not store the table select");

    // the pointer reads back as select over position
    a_ptr_readback: assert property (
        in_data && !req.write && hit_ptr
        |=> hrdata == {26'h000_0000, $past(sel), $past(pos)})
        else $error("pointer read returned wrong value");

    // automatic walk: red to green keeps the position
    a_auto_same_pos: assert property (
        acc_data && auto_sel && phase == pla_pkg::PLA_CH_RED
        |=> phase == pla_pkg::PLA_CH_GREEN && pos == $past(pos))
        else $error("auto step from red did not go to green");

    // automatic walk: green to blue keeps the position
    a_auto_green_blue: assert property (
        acc_data && auto_sel && phase == pla_pkg::PLA_CH_GREEN
        |=> phase == pla_pkg::PLA_CH_BLUE && pos == $past(pos))
        else $error("auto step from green did not go to blue");

    // automatic walk: blue moves on to red at the next position
    a_auto_wrap_red: assert property (
        acc_data && auto_sel && phase == pla_pkg::PLA_CH_BLUE
        |=> phase == pla_pkg::PLA_CH_RED && pos == 4'($past(pos) + 4'h1))
        else $error("auto step from blue did not move to next red");

    // one table selected: every access steps by one
    a_single_step: assert property (
        acc_data && sel != pla_pkg::PLA_SEL_AUTO |=> pos == 4'($past(pos) + 4'h1))
        else $error("single table access did not step position");

    // the last entry wraps back to the first
    a_single_wrap: assert property (
        acc_data && !auto_sel && pos == 4'hF |=> pos == 4'h0)
        else $error("position did not wrap past entry fifteen");

    // monochrome reads come from the gray table, judged by the data returned
    a_mono_green: assert property (
        in_data && !req.write && hit_data && !colour_mode
        |=> hrdata == {28'h000_0000, $past(lut[1][pos])})
        else $error("monochrome access not routed to green");

    // monochrome accesses step by one whatever the select
    a_mono_step: assert property (
        acc_data && !colour_mode |=> pos == 4'($past(pos) + 4'h1))
        else $error("monochrome access did not step position");

    // a window read returns the entry before the pointer moves
    a_read_window: assert property (
        in_data && !req.write && hit_data |=> hrdata == {28'h000_0000, $past(entry)})
        else $error("data window read returned wrong entry");

    // a window write reaches the gray table at the old position
    a_write_lands: assert property (
        wr_data && tgt == pla_pkg::PLA_CH_GREEN
        |=> lut[1][$past(pos)] == $past(hwdata[3:0]))
        else $error("data window write did not reach the table");

    // data window writes answer with zero read data
    a_write_zero: assert property (
        in_data && req.write && hit_data |=> hrdata == 32'h0000_0000)
        else $error("write answered with stale read data");

    // bank register keeps the low six bits
    a_bank_write: assert property (
        wr_bank |=> bank == $past(hwdata[5:0]))
        else $error("bank select write not stored");

    // the bank register reads back with its unused bits at zero
    a_bank_readback: assert property (
        in_data && !req.write && hit_bank
        |=> hrdata == {26'h000_0000, $past(bank)})
        else $error("bank select read returned wrong value");

    ////////////////////////////////////////////////////////////////////////////
    // checks: bus and clock enable

    // every transfer gets exactly one wait state
    a_bus_wait_one: assert property (
        take |=> !hreadyout ##1 hreadyout)
        else $error("bus answer not after exactly one wait state");

    // a low clock enable holds every register; the default disable would hide it
    a_ce_freeze: assert property (
        disable iff (rst) !ce |=> $stable(pos) && $stable(sel) && $stable(bank)
        && $stable(phase) && $stable(rgb_out) && $stable(hreadyout))
        else $error("state moved while clock enable was low");

    ////////////////////////////////////////////////////////////////////////////
    // checks: display lookup

    // 1 bpp red and blue stay in their lower eight entries
    a_red_blue_1bpp: assert property (
        bpp == pla_pkg::PLA_BPP1 |-> lidx[0] == {1'b0, bank[5:4], pixel[0]}
        && lidx[2] == {1'b0, bank[1:0], pixel[0]})
        else $error("1 bpp red or blue bank wrong");

    // 1 bpp green bank comes from bank bits 3-2
    a_green_1bpp: assert property (
        bpp == pla_pkg::PLA_BPP1 |-> lidx[1] == {1'b0, bank[3:2], pixel[0]})
        else $error("1 bpp green bank wrong");

    // 2 bpp: four banks of four in every table
    a_banks_2bpp: assert property (
        bpp == pla_pkg::PLA_BPP2 |-> lidx[0] == {bank[5:4], pixel[1:0]}
        && lidx[1] == {bank[3:2], pixel[1:0]}
        && lidx[2] == {bank[1:0], pixel[1:0]})
        else $error("2 bpp bank split wrong");

    // 4 bpp ignores the bank register in every lane
    a_full_table_4bpp: assert property (
        bpp == pla_pkg::PLA_BPP4 |-> lidx[0] == pixel[3:0] && lidx[1] == pixel[3:0]
        && lidx[2] == pixel[3:0])
        else $error("bank select used at 4 bpp");

    // 8 bpp red: one bank bit over three pixel bits; blue: two over two
    a_blue_bank_8bpp: assert property (
        bpp == pla_pkg::PLA_BPP8 |-> lidx[2] == {bank[1:0], pixel[1:0]}
        && lidx[0] == {bank[4], pixel[7:5]})
        else $error("8 bpp bank split wrong");

    // 8 bpp green uses bank bit 2 only
    a_green_bank_8bpp: assert property (
        bpp == pla_pkg::PLA_BPP8 |-> lidx[1] == {bank[2], pixel[4:2]})
        else $error("8 bpp green bank wrong");

    // colour is last cycle's lookup; tables start unloaded, so case equality
    a_rgb_follow: assert property (
        1'b1 |=> rgb_out === {$past(lval[0]), $past(lval[1]), $past(lval[2])})
        else $error("display colour did not follow lookup");

endmodule

/* verif/tb_top.sv */
// self-checking bench for the palette access block
`timescale 1ns/1ns
`include "pla_cfg.svh"
module tb_top;
    logic              core_clk    = 1'b0;
    logic              rst         = 1'b1;
    logic              ce          = 1'b1;
    logic              hsel        = 1'b0;
    logic [31:0]       haddr       = 32'h0000_0000;
    logic [1:0]        htrans      = 2'h0;
    logic              hwrite      = 1'b0;
    logic [31:0]       hwdata      = 32'h0000_0000;
    logic              hreadyout;
    logic              hresp;
    logic [31:0]       hrdata;
    logic              colour_mode = 1'b1;
    pla_pkg::pla_bpp_t bpp         = pla_pkg::PLA_BPP4;
    logic [7:0]        pixel       = 8'h00;
    pla_pkg::pla_rgb_t rgb_out;
    logic [31:0]       exp_rd[$];
    logic [11:0]       exp_px[$];
    logic              rd_pend     = 1'b0;
    logic              px_pend     = 1'b0;
    logic              px_d        = 1'b0;
    logic [3:0]        tbl[3][16];
    logic [5:0]        bank        = 6'h00;
    int                miscompares = 0;
    int                n_compared  = 0;
    int                cycles      = 0;
    int                seed        = 23;

    // hready is this slave's own hreadyout; hsize is fixed to a word
    pla_palette pla_palette_i (
        .core_clk(core_clk), .rst(rst), .ce(ce), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .colour_mode(colour_mode), .bpp(bpp), .pixel(pixel), .rgb_out(rgb_out)
    );

    always #4 core_clk = ~core_clk;

    ////////////////////////////////////////////////////////////////////////////
    // comparison and closing report
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        n_compared++;
        if (seen !== want)
        begin
            miscompares++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic test_done;
        // notes never taken off the queue mean a result that never showed
        if (exp_rd.size() + exp_px.size() != 0)
            miscompares++;
        $display("compared %0d, mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // single transfer; waits on hready rather than assuming a wait count
    task automatic xfer(input logic [9:0] a, input logic wr, input logic [31:0] d,
                        input logic [31:0] want);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {22'h0, a};
        hwrite <= wr;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        rd_pend <= !wr;
        if (!wr)
            exp_rd.push_back(want);
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        rd_pend <= 1'b0;
    endtask

    task automatic rd(input logic [9:0] a, input logic [31:0] want);
        xfer(a, 1'b0, 32'h0000_0000, want);
    endtask

    // expected colour from the bench's own copy of the tables
    function automatic logic [11:0] rgb_exp(input pla_pkg::pla_bpp_t m, input logic [7:0] p);
        logic [3:0] ix[3];
        for (int c = 0; c < 3; c++)
        begin
            case (m)
                pla_pkg::PLA_BPP1: ix[c] = {1'b0, bank[5-2*c -: 2], p[0]};
                pla_pkg::PLA_BPP2: ix[c] = {bank[5-2*c -: 2], p[1:0]};
                pla_pkg::PLA_BPP4: ix[c] = p[3:0];
                default: ix = '{{bank[4], p[7:5]}, {bank[2], p[4:2]}, {bank[1:0], p[1:0]}};
            endcase
        end
        return {tbl[0][ix[0]], tbl[1][ix[1]], tbl[2][ix[2]]};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // output watcher: oldest note is taken when a result shows; also cuts hangs
    always @(posedge core_clk)
    begin
        px_d <= px_pend;
        if (rd_pend && hreadyout === 1'b1 && exp_rd.size() > 0)
        begin
            check(hrdata, exp_rd.pop_front());
            check({31'h0000_0000, hresp}, 32'h0000_0000);
        end
        if (px_d && exp_px.size() > 0)
            check({20'h0, rgb_out}, {20'h0, exp_px.pop_front()});
        cycles++;
        if (cycles == 6000)
        begin
            miscompares++;
            test_done();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        logic [31:0] r;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        // fill all tables through the automatic walk, upper data bits random
        xfer(`PLA_ADDR_POINTER, 1'b1, 32'h0000_0000, 0);
        for (int i = 0; i < 48; i++)
        begin
            r = $random(seed);
            tbl[i % 3][i / 3] = r[3:0];
            xfer(`PLA_ADDR_DATA, 1'b1, r, 0);
        end
        rd(`PLA_ADDR_POINTER, 32'h0000_0000);
        // each single table read back in full, then the wrapped pointer
        for (int s = 1; s < 4; s++)
        begin
            xfer(`PLA_ADDR_POINTER, 1'b1, s << 4, 0);
            for (int p = 0; p < 16; p++)
                rd(`PLA_ADDR_DATA, {28'h0, tbl[s-1][p]});
            rd(`PLA_ADDR_POINTER, s << 4);
        end
        // automatic walk across the top entry, wraps back to red at zero
        xfer(`PLA_ADDR_POINTER, 1'b1, 32'h0000_000D, 0);
        for (int i = 0; i < 9; i++)
            rd(`PLA_ADDR_DATA, {28'h0, tbl[i % 3][13 + i / 3]});
        rd(`PLA_ADDR_POINTER, 32'h0000_0000);
        rd(`PLA_ADDR_DATA, {28'h0, tbl[0][0]});
        // monochrome goes to green with select 10b and with select 00
        colour_mode <= 1'b0;
        xfer(`PLA_ADDR_POINTER, 1'b1, 32'h0000_002F, 0);
        rd(`PLA_ADDR_DATA, {28'h0, tbl[1][15]});
        rd(`PLA_ADDR_POINTER, 32'h0000_0020);
        xfer(`PLA_ADDR_POINTER, 1'b1, 32'h0000_0005, 0);
        rd(`PLA_ADDR_DATA, {28'h0, tbl[1][5]});
        rd(`PLA_ADDR_DATA, {28'h0, tbl[1][6]});
        colour_mode <= 1'b1;
        // unused bank bits and an unmapped address read zero
        xfer(`PLA_ADDR_BANK, 1'b1, 32'hFFFF_FFFF, 0);
        rd(`PLA_ADDR_BANK, 32'h0000_003F);
        rd(10'h060, 32'h0000_0000);
        // display lookups over every depth with random banks and pixels
        for (int i = 0; i < 24; i++)
        begin
            r = $random(seed);
            bank = r[13:8];
            xfer(`PLA_ADDR_BANK, 1'b1, {26'h0, bank}, 0);
            bpp <= pla_pkg::pla_bpp_t'(i % 4);
            pixel <= r[7:0];
            px_pend <= 1'b1;
            exp_px.push_back(rgb_exp(pla_pkg::pla_bpp_t'(i % 4), r[7:0]));
            @(posedge core_clk);
            px_pend <= 1'b0;
            repeat (2) @(posedge core_clk);
        end
        // frozen clock enable must hold the colour whatever the pixel does
        ce <= 1'b0;
        pixel <= ~pixel;
        px_pend <= 1'b1;
        exp_px.push_back(rgb_exp(bpp, pixel));
        @(posedge core_clk);
        px_pend <= 1'b0;
        repeat (2) @(posedge core_clk);
        ce <= 1'b1;
        test_done();
    end
endmodule
